// *** design/kbiu_sync.sv ***
// two-flop synchroniser for the eight key pins
// assumes pins idle high; resets to all high so no edge follows reset
`timescale 1ns/1ns
module kbiu_sync
	import kbiu_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 resetn,
	input  wire logic [KBIU_PINS-1:0] pins_raw,
	output      logic [KBIU_PINS-1:0] pins_sync
);

	kbiu_sync_state_t sync_ff;
	kbiu_sync_state_t nxt_sync;

	always_comb begin
		nxt_sync = sync_ff;
		nxt_sync.stage1 = pins_raw;
		// first stage feeds only the second stage
		nxt_sync.stage2 = sync_ff.stage1;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			sync_ff <= {KBIU_RST_SYNC, KBIU_RST_SYNC};
		end else begin
			sync_ff <= nxt_sync;
		end
	end

	assign pins_sync = sync_ff.stage2;

endmodule

// *** design/kbiu_top.sv ***
// keypad interrupt unit: pin enables, request latch, mask and flag
// assumes pin inputs idle high, a one-cycle vector fetch pulse from
// the cpu, and break state and break-clear enable from the system unit
//
// Function
// R1 - eight port pins share one mask and request
// R2 - each enable bit selects its pin independently
// R3 - enabled pin also gets its pullup turned on
// R4 - latch when an enabled pin falls, all high before
// R5 - edge mode ignores falls while another pin low
// R6 - level mode holds request while any pin low
// R7 - level mode clears after acknowledge and all high
// R8 - edge mode acknowledge clears request at once
// R9 - vector fetch acknowledges and clears the request
// R10 - acknowledge bit write-one, reads zero, reset clear
// R11 - falls after acknowledge latch a new request
// R12 - unmasked request makes cpu use vector FFE0/FFE1
// R13 - mask bit blocks request to cpu, reset clear
// R14 - pending flag shows latch regardless of mask
// R15 - reset clears request and sensitivity despite low pin
// R16 - sensitivity one: edges and levels; zero: edges
// R17 - enable forces pin input; reads still need direction
// R18 - status bits seven to four read zero
// R19 - reset clears all pin enable bits
// R20 - software masks, enables, acknowledges, then unmasks
// R21 - software delays level-mode acknowledge for pullup charge
// R22 - software may drive pins high before enabling
// R23 - active in wait and stop, request wakes mcu
// R24 - break blocks acknowledge writes unless break-clear set
// R25 - vector fetch is a pulse; pins synchronised first
`timescale 1ns/1ns
module kbiu_top
	import kbiu_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 resetn,
	input  wire kbiu_bus_t            bus,
	output      logic [KBIU_DW-1:0]   rdata,
	input  wire logic [KBIU_PINS-1:0] port_a_pins,
	input  wire logic                 vector_fetch_ack,
	input  wire logic                 break_active,
	input  wire logic                 break_clear_enable,
	output      logic [KBIU_PINS-1:0] pullup_enable,
	output      logic [KBIU_PINS-1:0] force_input,
	output      logic                 cpu_irq,
	output      logic                 wake_request
);

	kbiu_state_t          st_ff;
	kbiu_state_t          nxt_st;
	logic [KBIU_PINS-1:0] pins_sync;
	logic                 any_low;
	logic                 fall_event;
	logic                 wr_status;
	logic                 wr_enable;
	logic                 sw_ack;
	logic                 ack;
	logic                 ack_blocked;

	kbiu_sync u_sync (
		.clock     (clock),
		.resetn    (resetn),
		.pins_raw  (port_a_pins),
		.pins_sync (pins_sync)
	);

	// only enabled pins take part; disabled pins count as high
	assign any_low    = |(~pins_sync & st_ff.pin_enable); // R1 R2
	// a fall counts only when no enabled pin was low the cycle before
	assign fall_event = any_low && st_ff.none_low; // R4 R5

	assign wr_status = bus.wr && (bus.addr == KBIU_OFS_STATUS_CONTROL);
	assign wr_enable = bus.wr && (bus.addr == KBIU_OFS_PIN_ENABLE);

	// acknowledge writes are held off while break protects the latch
	assign ack_blocked = break_active && !break_clear_enable; // R24
	assign sw_ack = wr_status && bus.wdata[KBIU_BIT_ACK] && !ack_blocked; // R10 R24
	// vector fetch is not subject to the break hold-off
	assign ack = sw_ack || vector_fetch_ack; // R9 R25

	always_comb begin
		nxt_st = st_ff;
		nxt_st.none_low = !any_low;

		if (wr_enable) begin
			nxt_st.pin_enable = bus.wdata[KBIU_PINS-1:0]; // R2
		end
		if (wr_status) begin
			nxt_st.sensitivity = bus.wdata[KBIU_BIT_SENSITIVITY]; // R16
			nxt_st.mask        = bus.wdata[KBIU_BIT_MASK]; // R13
		end

		if (fall_event) begin
			// a new fall wins over an acknowledge in the same cycle
			nxt_st.request  = 1'b1; // R4 R11
			nxt_st.ack_seen = 1'b0; // R11
		end else if (st_ff.sensitivity == KBIU_SENS_EDGE_LEVEL) begin
			if (any_low) begin
				nxt_st.request  = 1'b1; // R6
				nxt_st.ack_seen = st_ff.ack_seen || ack; // R7
			end else if (ack || st_ff.ack_seen) begin
				// ack and release may come in either order
				nxt_st.request  = 1'b0; // R7
				nxt_st.ack_seen = 1'b0;
			end
		end else if (ack) begin
			nxt_st.request  = 1'b0; // R8
			nxt_st.ack_seen = 1'b0;
		end

		// read data stand one cycle, zero otherwise
		nxt_st.rdata = KBIU_RST_RDATA;
		if (bus.rd) begin
			unique case (bus.addr)
				KBIU_OFS_STATUS_CONTROL: begin
					nxt_st.rdata[KBIU_BIT_PENDING]     = st_ff.request; // R14
					nxt_st.rdata[KBIU_BIT_SENSITIVITY] = st_ff.sensitivity;
					nxt_st.rdata[KBIU_BIT_MASK]        = st_ff.mask;
					// acknowledge and bits seven to four stay zero
					nxt_st.rdata[KBIU_BIT_ACK] = 1'b0; // R10 R18
				end
				KBIU_OFS_PIN_ENABLE: begin
					nxt_st.rdata = st_ff.pin_enable;
				end
				default: begin
					nxt_st.rdata = KBIU_RST_RDATA;
				end
			endcase
		end

		// no clock gating here, so wait and stop leave the unit running
		nxt_st.irq  = nxt_st.request && !nxt_st.mask; // R12 R13
		nxt_st.wake = nxt_st.request && !nxt_st.mask; // R23
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			st_ff.pin_enable  <= KBIU_RST_PIN_ENABLE; // R19
			st_ff.sensitivity <= KBIU_RST_SENS; // R15
			st_ff.mask        <= KBIU_RST_MASK;
			st_ff.request     <= KBIU_RST_REQUEST; // R15
			st_ff.ack_seen    <= 1'b0;
			st_ff.none_low    <= 1'b1;
			st_ff.rdata       <= KBIU_RST_RDATA;
			st_ff.irq         <= 1'b0;
			st_ff.wake        <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// pullup and direction override follow the registered enables;
	// reading the pin level stays the port logic's job
	assign pullup_enable = st_ff.pin_enable; // R3
	assign force_input   = st_ff.pin_enable; // R17
	assign cpu_irq       = st_ff.irq; // R12
	assign wake_request  = st_ff.wake; // R23
	assign rdata         = st_ff.rdata;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	logic was_rd_status;
	always_ff @(posedge clock) begin
		if (!resetn) begin
			was_rd_status <= 1'b0;
		end else begin
			was_rd_status <= bus.rd && (bus.addr == KBIU_OFS_STATUS_CONTROL);
		end
	end

	logic was_rd_enable;
	always_ff @(posedge clock) begin
		if (!resetn) begin
			was_rd_enable <= 1'b0;
		end else begin
			was_rd_enable <= bus.rd && (bus.addr == KBIU_OFS_PIN_ENABLE);
		end
	end

	status_read_zero_a: assert property ( // R10
		was_rd_status |-> (rdata[KBIU_BIT_ACK] == 1'b0)
	) else $error("acknowledge bit read back nonzero");

	status_upper_zero_a: assert property ( // R18
		was_rd_status |-> (rdata[7:4] == 4'h0)
	) else $error("status upper bits read nonzero");

	pending_flag_read_a: assert property ( // R14
		was_rd_status |-> (rdata[KBIU_BIT_PENDING] == $past(st_ff.request))
	) else $error("pending flag does not show latch");

	fall_latches_a: assert property ( // R4
		fall_event |=> st_ff.request
	) else $error("fall did not latch request");

	edge_no_relatch_a: assert property ( // R5
		(!st_ff.request && !st_ff.none_low && !ack &&
		 st_ff.sensitivity == KBIU_SENS_EDGE && !wr_status) |=> !st_ff.request
	) else $error("edge mode latched while a pin was low");

	level_holds_a: assert property ( // R6
		(st_ff.sensitivity == KBIU_SENS_EDGE_LEVEL && any_low) |=> st_ff.request
	) else $error("level mode dropped request with pin low");

	level_clear_a: assert property ( // R7
		(st_ff.sensitivity == KBIU_SENS_EDGE_LEVEL && st_ff.request &&
		 !any_low && (ack || st_ff.ack_seen)) |=> !st_ff.request
	) else $error("level mode did not clear after ack and release");

	edge_ack_clear_a: assert property ( // R8
		(st_ff.sensitivity == KBIU_SENS_EDGE && ack && !fall_event) |=> !st_ff.request
	) else $error("edge mode ack did not clear request");

	break_protect_a: assert property ( // R24
		(break_active && !break_clear_enable && !vector_fetch_ack &&
		 st_ff.request && st_ff.sensitivity == KBIU_SENS_EDGE) |=> st_ff.request
	) else $error("ack write cleared latch during protected break");

	mask_gates_a: assert property ( // R13
		(st_ff.mask || !st_ff.request) |-> !cpu_irq
	) else $error("masked or idle request reached cpu");

	irq_follows_a: assert property ( // R12
		(st_ff.request && !st_ff.mask) |-> (cpu_irq && wake_request)
	) else $error("unmasked request not presented");

	pullup_tracks_a: assert property ( // R3
		wr_enable |=> (pullup_enable == $past(bus.wdata) && force_input == pullup_enable)
	) else $error("pullup does not follow pin enable");

	sync_delay_a: assert property ( // R25
		$fell(port_a_pins[0]) && st_ff.pin_enable[0] && st_ff.none_low &&
		(&(pins_sync | ~st_ff.pin_enable)) && !wr_enable |-> ##2 fall_event
	) else $error("pin fall not seen two cycles later");

	status_mask_read_a: assert property ( // R13
		was_rd_status |-> (rdata[KBIU_BIT_MASK] == $past(st_ff.mask))
	) else $error("mask bit read back wrong");

	status_sens_read_a: assert property ( // R16
		was_rd_status |-> (rdata[KBIU_BIT_SENSITIVITY] == $past(st_ff.sensitivity))
	) else $error("sensitivity bit read back wrong");

	enable_read_a: assert property ( // R2
		was_rd_enable |-> (rdata == $past(st_ff.pin_enable))
	) else $error("pin enable register read back wrong");

	enable_write_a: assert property ( // R2
		wr_enable |=> (st_ff.pin_enable == $past(bus.wdata))
	) else $error("pin enable write did not land");

	mask_write_a: assert property ( // R13
		wr_status |=> (st_ff.mask == $past(bus.wdata[KBIU_BIT_MASK]))
	) else $error("mask write did not land");

	sens_write_a: assert property ( // R16
		wr_status |=> (st_ff.sensitivity == $past(bus.wdata[KBIU_BIT_SENSITIVITY]))
	) else $error("sensitivity write did not land");

	vector_clear_a: assert property ( // R9
		(vector_fetch_ack && !any_low) |=> !st_ff.request
	) else $error("vector fetch did not clear request");

	fall_wins_a: assert property ( // R11
		(fall_event && ack) |=> st_ff.request
	) else $error("acknowledge swallowed a fresh fall");

	edge_holds_a: assert property ( // R8
		(st_ff.sensitivity == KBIU_SENS_EDGE && st_ff.request && !ack) |=> st_ff.request
	) else $error("edge mode request dropped without acknowledge");

	level_remembers_a: assert property ( // R7
		(st_ff.sensitivity == KBIU_SENS_EDGE_LEVEL && st_ff.request &&
		 !ack && !st_ff.ack_seen) |=> st_ff.request
	) else $error("level mode request dropped without acknowledge");

	ack_memory_a: assert property ( // R7
		(st_ff.sensitivity == KBIU_SENS_EDGE_LEVEL && any_low && ack &&
		 !fall_event) |=> st_ff.ack_seen
	) else $error("level mode forgot an early acknowledge");

	no_spurious_a: assert property ( // R4
		(!st_ff.request && !fall_event &&
		 !(st_ff.sensitivity == KBIU_SENS_EDGE_LEVEL && any_low)) |=> !st_ff.request
	) else $error("request latched without a cause");

	disabled_quiet_a: assert property ( // R2
		(st_ff.pin_enable == KBIU_RST_PIN_ENABLE && !st_ff.request) |=> !st_ff.request
	) else $error("request latched with no pin enabled");

	reset_clear_a: assert property ( // R15
		$rose(resetn) |-> (!st_ff.request && st_ff.sensitivity == KBIU_RST_SENS)
	) else $error("reset left request or sensitivity set");

	reset_enables_a: assert property ( // R19
		$rose(resetn) |-> (st_ff.pin_enable == KBIU_RST_PIN_ENABLE && !cpu_irq &&
		 rdata == KBIU_RST_RDATA)
	) else $error("reset left pin enables or outputs set");

	break_clear_ok_a: assert property ( // R24
		(break_active && break_clear_enable && sw_ack && !fall_event &&
		 st_ff.sensitivity == KBIU_SENS_EDGE) |=> !st_ff.request
	) else $error("allowed break acknowledge did not clear");

	fall_forgets_a: assert property ( // R11
		fall_event |=> !st_ff.ack_seen
	) else $error("fresh fall kept an old acknowledge");

	none_low_track_a: assert property ( // R5
		st_ff.none_low == !$past(any_low)
	) else $error("previous all-high state tracked wrong");

	irq_latency_a: assert property ( // R12
		(fall_event && !st_ff.mask && !wr_status) |=> cpu_irq
	) else $error("unmasked fall did not reach cpu next cycle");

	mask_immediate_a: assert property ( // R13
		(wr_status && bus.wdata[KBIU_BIT_MASK]) |=> !cpu_irq
	) else $error("mask write did not block cpu request");

	pending_holds_a: assert property ( // R14
		(wr_status && !ack && !st_ff.ack_seen && st_ff.request) |=>
		 st_ff.request
	) else $error("register write without acknowledge cleared pending");

	wake_masked_a: assert property ( // R23
		(st_ff.mask || !st_ff.request) |-> !wake_request
	) else $error("masked or idle request woke the mcu");

	edge_irq_c: cover property (
		st_ff.sensitivity == KBIU_SENS_EDGE && fall_event ##1 cpu_irq
	);
	level_ack_then_release_c: cover property (
		st_ff.sensitivity == KBIU_SENS_EDGE_LEVEL && any_low && ack ##[1:20] !st_ff.request
	);
	break_blocked_c: cover property (
		wr_status && bus.wdata[KBIU_BIT_ACK] && ack_blocked && st_ff.request
	);
	vector_fetch_clear_c: cover property (
		vector_fetch_ack && st_ff.request ##1 !st_ff.request
	);
	unmask_pending_c: cover property (
		st_ff.request && st_ff.mask ##1 !st_ff.mask && cpu_irq
	);

endmodule

// *** pkg/kbiu_pkg.sv ***
// constants, bus carrier and state types for the keypad interrupt unit
// assumes one 10 MHz bus clock and a synchronous active-low reset
package kbiu_pkg;

	// clock rate, for reference by anything that turns times into counts
	localparam int unsigned KBIU_CLOCK_HZ = 10_000_000;

	localparam int unsigned KBIU_PINS = 8;
	localparam int unsigned KBIU_AW   = 8;
	localparam int unsigned KBIU_DW   = 8;

	// register offsets on the plain register port
	localparam logic [KBIU_AW-1:0] KBIU_OFS_STATUS_CONTROL = 8'h00;
	localparam logic [KBIU_AW-1:0] KBIU_OFS_PIN_ENABLE     = 8'h01;

	// key_status_control field positions
	localparam int unsigned KBIU_BIT_SENSITIVITY = 0;
	localparam int unsigned KBIU_BIT_MASK        = 1;
	localparam int unsigned KBIU_BIT_ACK         = 2;
	localparam int unsigned KBIU_BIT_PENDING     = 3;

	// reset values
	localparam logic [KBIU_PINS-1:0] KBIU_RST_PIN_ENABLE = 8'h00;
	localparam logic                 KBIU_RST_SENS       = 1'b0;
	localparam logic                 KBIU_RST_MASK       = 1'b0;
	localparam logic                 KBIU_RST_REQUEST    = 1'b0;
	localparam logic [KBIU_PINS-1:0] KBIU_RST_SYNC       = 8'hFF;
	localparam logic [KBIU_DW-1:0]   KBIU_RST_RDATA      = 8'h00;

	// sensitivity encodings
	localparam logic KBIU_SENS_EDGE       = 1'b0;
	localparam logic KBIU_SENS_EDGE_LEVEL = 1'b1;

	// vector location the cpu uses for this request
	localparam logic [15:0] KBIU_VECTOR_HIGH = 16'hFFE0;
	localparam logic [15:0] KBIU_VECTOR_LOW  = 16'hFFE1;

	typedef struct packed {
		logic [KBIU_AW-1:0] addr;
		logic [KBIU_DW-1:0] wdata;
		logic               wr;
		logic               rd;
	} kbiu_bus_t;

	typedef struct packed {
		logic [KBIU_PINS-1:0] stage1;
		logic [KBIU_PINS-1:0] stage2;
	} kbiu_sync_state_t;

	typedef struct packed {
		logic [KBIU_PINS-1:0] pin_enable;
		logic                 sensitivity;
		logic                 mask;
		logic                 request;
		logic                 ack_seen;
		logic                 none_low;
		logic [KBIU_DW-1:0]   rdata;
		logic                 irq;
		logic                 wake;
	} kbiu_state_t;

endpackage

// *** tb/kbiu_keys.sv ***
// keys and switches standing on the eight port pins of the unit
// assumes pullup_enable and force_input come from the unit, drive_high
// is the port output driving one; a pressed key pulls low
`timescale 1ns/1ns
module kbiu_keys
	import kbiu_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic [KBIU_PINS-1:0] pullup_enable,
	input  wire logic [KBIU_PINS-1:0] force_input,
	input  wire logic [KBIU_PINS-1:0] drive_high,
	input  wire logic [KBIU_PINS-1:0] press,
	output      logic [KBIU_PINS-1:0] pins
);
	logic float_ff = 1'b0;

	// an open pin with no pullup wanders, so it never settles quietly
	always @(posedge clock) float_ff <= ~float_ff;

	always_comb begin
		for (int i = 0; i < KBIU_PINS; i++) begin
			if (drive_high[i] && !force_input[i]) begin
				// a driving port output beats a key until the enable forces input
				pins[i] = 1'b1;
			end else begin
				pins[i] = press[i] ? 1'b0 : (pullup_enable[i] ? 1'b1 : float_ff);
			end
		end
	end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the keypad interrupt unit
// assumes the register port, key model and a 100 ns bus clock
`timescale 1ns/1ns
module tb_top
	import kbiu_pkg::*;
;
	logic                 clock = 1'b0;
	logic                 resetn = 1'b0;
	kbiu_bus_t            bus_s;
	logic [KBIU_DW-1:0]   rdata;
	logic [KBIU_PINS-1:0] port_a_pins;
	logic [KBIU_PINS-1:0] press;
	logic [KBIU_PINS-1:0] drive_high;
	logic [KBIU_PINS-1:0] pullup_enable;
	logic [KBIU_PINS-1:0] force_input;
	logic                 vector_fetch_ack;
	logic                 break_active;
	logic                 break_clear_enable;
	logic                 cpu_irq;
	logic                 wake_request;
	int                   num_errors = 0;
	int                   compares = 0;
	int                   cycles = 0;

	always #50 clock = ~clock;

	kbiu_top DUT (.clock, .resetn, .bus(bus_s), .rdata, .port_a_pins, .vector_fetch_ack,
		.break_active, .break_clear_enable, .pullup_enable, .force_input, .cpu_irq,
		.wake_request);

	kbiu_keys keys_m (.clock, .pullup_enable, .force_input, .drive_high, .press,
		.pins(port_a_pins));

	task automatic print_verdict;
		$display("errors %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			print_verdict;
		end
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_s <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus_s.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		bus_s <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus_s.rd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask

	task automatic chk_req(input logic exp, input logic m, input logic s);
		logic [7:0] d;
		rd(KBIU_OFS_STATUS_CONTROL, d);
		chk("status", d, {4'h0, exp, 1'b0, m, s});
		chk("cpu_irq", {7'h00, cpu_irq}, {7'h00, exp & ~m});
		chk("wake_request", {7'h00, wake_request}, {7'h00, exp & ~m});
	endtask

	// three edges of synchroniser and latch, one spare
	task automatic keys(input logic [7:0] p);
		@(posedge clock);
		press <= p;
		repeat (4) @(posedge clock);
	endtask

	task automatic do_reset;
		@(posedge clock);
		resetn <= 1'b0;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
	endtask

	// masked while the fresh pullup charges the pin, then acknowledged
	task automatic setup(input logic [7:0] en, input logic s);
		wr(KBIU_OFS_STATUS_CONTROL, {7'h00, s} | 8'h02);
		wr(KBIU_OFS_PIN_ENABLE, en);
		repeat (4) @(posedge clock);
		wr(KBIU_OFS_STATUS_CONTROL, {7'h00, s} | 8'h06);
		wr(KBIU_OFS_STATUS_CONTROL, {7'h00, s});
		@(negedge clock);
		chk("pullup_enable", pullup_enable, en);
		chk("force_input", force_input, en);
	endtask

	task automatic t_reset;
		logic [7:0] d;
		chk_req(1'b0, 1'b0, 1'b0);
		rd(KBIU_OFS_PIN_ENABLE, d);
		chk("pin_enable", d, KBIU_RST_PIN_ENABLE);
		rd(8'h7F, d);
		chk("unmapped", d, 8'h00);
		wr(KBIU_OFS_STATUS_CONTROL, 8'hFB);
		chk_req(1'b0, 1'b1, 1'b1);
		wr(KBIU_OFS_STATUS_CONTROL, 8'h00);
	endtask

	task automatic t_edge;
		setup(8'h03, KBIU_SENS_EDGE);
		keys(8'h01);
		chk_req(1'b1, 1'b0, 1'b0);
		wr(KBIU_OFS_STATUS_CONTROL, 8'h04);
		chk_req(1'b0, 1'b0, 1'b0);
		keys(8'h03);
		chk_req(1'b0, 1'b0, 1'b0);
		keys(8'h00);
		keys(8'h02);
		chk_req(1'b1, 1'b0, 1'b0);
		@(posedge clock);
		vector_fetch_ack <= 1'b1;
		@(posedge clock);
		vector_fetch_ack <= 1'b0;
		chk_req(1'b0, 1'b0, 1'b0);
		keys(8'h04);
		chk_req(1'b0, 1'b0, 1'b0);
		keys(8'h00);
	endtask

	task automatic t_mask;
		wr(KBIU_OFS_STATUS_CONTROL, 8'h02);
		keys(8'h01);
		chk_req(1'b1, 1'b1, 1'b0);
		wr(KBIU_OFS_STATUS_CONTROL, 8'h00);
		chk_req(1'b1, 1'b0, 1'b0);
		wr(KBIU_OFS_STATUS_CONTROL, 8'h04);
		keys(8'h00);
	endtask

	task automatic t_level;
		setup(8'h01, KBIU_SENS_EDGE_LEVEL);
		keys(8'h01);
		chk_req(1'b1, 1'b0, 1'b1);
		wr(KBIU_OFS_STATUS_CONTROL, 8'h05);
		chk_req(1'b1, 1'b0, 1'b1);
		keys(8'h00);
		chk_req(1'b0, 1'b0, 1'b1);
		keys(8'h01);
		keys(8'h00);
		chk_req(1'b1, 1'b0, 1'b1);
		wr(KBIU_OFS_STATUS_CONTROL, 8'h05);
		chk_req(1'b0, 1'b0, 1'b1);
	endtask

	task automatic t_break;
		setup(8'h01, KBIU_SENS_EDGE);
		@(posedge clock);
		break_active <= 1'b1;
		keys(8'h01);
		wr(KBIU_OFS_STATUS_CONTROL, 8'h04);
		chk_req(1'b1, 1'b0, 1'b0);
		@(posedge clock);
		break_clear_enable <= 1'b1;
		wr(KBIU_OFS_STATUS_CONTROL, 8'h04);
		break_active <= 1'b0;
		break_clear_enable <= 1'b0;
		chk_req(1'b0, 1'b0, 1'b0);
		keys(8'h00);
	endtask

	task automatic t_reset_low;
		logic [7:0] d;
		setup(8'h01, KBIU_SENS_EDGE_LEVEL);
		keys(8'h01);
		chk_req(1'b1, 1'b0, 1'b1);
		do_reset;
		chk_req(1'b0, 1'b0, 1'b0);
		rd(KBIU_OFS_PIN_ENABLE, d);
		chk("pin_enable", d, 8'h00);
		keys(8'h00);
	endtask

	// pin driven high by its port output before enabling, pullup holding it once enabled: no false request
	task automatic t_drive;
		@(posedge clock);
		drive_high <= 8'h10;
		repeat (3) @(posedge clock);
		wr(KBIU_OFS_PIN_ENABLE, 8'h10);
		repeat (4) @(posedge clock);
		chk_req(1'b0, 1'b0, 1'b0);
		keys(8'h10);
		chk_req(1'b1, 1'b0, 1'b0);
		wr(KBIU_OFS_STATUS_CONTROL, 8'h04);
		keys(8'h00);
		drive_high <= 8'h00;
	endtask

	initial begin
		bus_s = '0;
		press = 8'h00;
		vector_fetch_ack = 1'b0;
		break_active = 1'b0;
		break_clear_enable = 1'b0;
		drive_high = 8'h00;
		do_reset;
		t_reset;
		t_edge;
		t_mask;
		t_level;
		t_break;
		t_reset_low;
		t_drive;
		print_verdict;
	end
endmodule
